// [ppc_defines.svh]
// Register offsets, field positions and reset values for the printer port controller
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

`define PPC_ADDR_W          10
`define PPC_OFS_DATA        10'h0378
`define PPC_OFS_STATUS      10'h0379
`define PPC_OFS_CONTROL     10'h037A

`define PPC_CTL_STROBE      0
`define PPC_CTL_AUTO_FEED   1
`define PPC_CTL_INIT        2
`define PPC_CTL_SELECT_IN   3
`define PPC_CTL_IRQ_EN      4
`define PPC_CTL_RSV_LO      5
`define PPC_CTL_RSV_HI      6
`define PPC_CTL_DIR         7

`define PPC_ST_UNUSED_HI    2
`define PPC_ST_ERROR        3
`define PPC_ST_ONLINE       4
`define PPC_ST_PAPER        5
`define PPC_ST_ACK          6
`define PPC_ST_BUSY         7

`define PPC_CTL_WR_MASK     8'h009F
`define PPC_DATA_RESET      8'h0000
`define PPC_CTL_RESET       8'h0000
`define PPC_STATUS_LOW_ZERO 3'h0
`define PPC_RDATA_IDLE      8'h00
`define PPC_OE_RESET        1'b1
`define PPC_CTL_OUT_RESET   4'hF
`define PPC_IRQ_RESET       1'b0

`endif

// [ppc_pkg.sv]
// Types shared by the printer port controller
`default_nettype none
package ppc_pkg;

   // Printer status inputs from the connector
   typedef struct packed {
      logic printer_occupied_flag;
      logic ack_n;
      logic paper_out_flag;
      logic printer_online_flag;
      logic error_n;
   } ppc_status_in_t;

   // Connector control outputs
   typedef struct packed {
      logic strobe_drive;
      logic auto_feed_drive;
      logic printer_init_drive;
      logic select_in_drive;
   } ppc_ctl_out_t;

endpackage : ppc_pkg
`default_nettype wire

// [ppc_printer_port.sv]
// Printer port controller: data, status and control registers on the CPU I/O bus
// Summary of operation
// - A write to the data register latches a byte that is driven onto the connector data lines.
// - A read of the data register returns the levels now present on the connector data lines.
// - Status bit 7 is the inverted busy line and status bits 2 to 0 carry no information.
// - Status bits 6 to 3 pass acknowledge, paper-end, selected and error uninverted.
// - The control register is writable and readable.
// - Control bit 4 forwards the port interrupt request to the system when set and blocks it when clear.
// - Control bit 7 set turns the data drivers off for input, clear drives the data register out.
// - Control bit 0 drives the strobe line inverted.
// - Control bit 1 drives auto-feed inverted and reads back the inverted level returned from that line.
// - Control bit 2 drives the initialize line with the written polarity.
// - Control bit 3 drives select-in inverted and reads back the inverted level returned from the connector.
// - With bidirection disable low the direction bit is ignored and the data lines stay outputs.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"

module ppc_printer_port (
   // Clock and reset
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst,
   // CPU I/O port access
   input  wire logic [`PPC_ADDR_W-1:0] i_io_addr,
   input  wire logic                   i_io_wr,
   input  wire logic                   i_io_rd,
   input  wire logic [7:0]             i_io_wdata,
   output logic      [7:0]             o_io_rdata,
   // Connector data lines
   input  wire logic [7:0]             i_pd,
   output logic      [7:0]             o_pd,
   output logic                        o_pd_oe,
   // Connector status and returned control levels
   input  wire ppc_pkg::ppc_status_in_t i_status,
   input  wire logic                   i_auto_feed_ret,
   input  wire logic                   i_select_in_ret,
   // Connector control outputs
   output ppc_pkg::ppc_ctl_out_t       o_ctl,
   // Interrupt and direction strap
   input  wire logic                   i_port_irq,
   input  wire logic                   i_bidirection_disable,
   output logic                        o_sys_irq
);

   // Synchroniser stages for connector and strap inputs
   logic [7:0]              pd_s1_r;
   logic [7:0]              pd_s2_r;
   ppc_pkg::ppc_status_in_t st_s1_r;
   ppc_pkg::ppc_status_in_t st_s2_r;
   logic                    af_ret_s1_r;
   logic                    af_ret_s2_r;
   logic                    sel_ret_s1_r;
   logic                    sel_ret_s2_r;
   logic                    dis_s1_r;
   logic                    dis_s2_r;

   // Register file
   logic [7:0]              data_r;
   logic [7:0]              ctl_r;
   logic [7:0]              data_nxt;
   logic [7:0]              ctl_nxt;

   // Read path and output next values
   logic [7:0]              rd_mux;
   wire  [7:0]              status_byte;
   wire  [7:0]              ctl_byte;
   logic [7:0]              rdata_nxt;
   logic                    pd_oe_nxt;
   wire ppc_pkg::ppc_ctl_out_t ctl_out_nxt;
   logic                    sys_irq_nxt;

   // Pins are asynchronous; no reset here, the stages flush within two edges
   always_ff @(posedge i_clk_sys) begin
      pd_s1_r <= i_pd;
   end

   always_ff @(posedge i_clk_sys) begin
      pd_s2_r <= pd_s1_r;
   end

   always_ff @(posedge i_clk_sys) begin
      st_s1_r <= i_status;
   end

   always_ff @(posedge i_clk_sys) begin
      st_s2_r <= st_s1_r;
   end

   always_ff @(posedge i_clk_sys) begin
      af_ret_s1_r <= i_auto_feed_ret;
   end

   always_ff @(posedge i_clk_sys) begin
      af_ret_s2_r <= af_ret_s1_r;
   end

   always_ff @(posedge i_clk_sys) begin
      sel_ret_s1_r <= i_select_in_ret;
   end

   always_ff @(posedge i_clk_sys) begin
      sel_ret_s2_r <= sel_ret_s1_r;
   end

   always_ff @(posedge i_clk_sys) begin
      dis_s1_r <= i_bidirection_disable;
   end

   always_ff @(posedge i_clk_sys) begin
      dis_s2_r <= dis_s1_r;
   end

   // Address decode
   wire sel_data = (i_io_addr == `PPC_OFS_DATA);
   wire sel_stat = (i_io_addr == `PPC_OFS_STATUS);
   wire sel_ctl  = (i_io_addr == `PPC_OFS_CONTROL);
   wire wr_data  = i_io_wr & sel_data;
   wire wr_ctl   = i_io_wr & sel_ctl;

   assign data_nxt = wr_data ? i_io_wdata : data_r;
   // Reserved bits are masked on the way in so they always read as zero
   assign ctl_nxt  = wr_ctl ? (i_io_wdata & `PPC_CTL_WR_MASK) : ctl_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         data_r <= `PPC_DATA_RESET;
      end else begin
         data_r <= data_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctl_r <= `PPC_CTL_RESET;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // Strap low forces output; the direction bit is still stored so it applies once the strap rises
   wire dir_input = ctl_r[`PPC_CTL_DIR] & dis_s2_r;
   assign pd_oe_nxt = ~dir_input;

   // Status byte; ack is active low on the wire and passed as is
   assign status_byte[`PPC_ST_BUSY]          = ~st_s2_r.printer_occupied_flag;
   assign status_byte[`PPC_ST_ACK]           = st_s2_r.ack_n;
   assign status_byte[`PPC_ST_PAPER]         = st_s2_r.paper_out_flag;
   assign status_byte[`PPC_ST_ONLINE]        = st_s2_r.printer_online_flag;
   assign status_byte[`PPC_ST_ERROR]         = st_s2_r.error_n;
   assign status_byte[`PPC_ST_UNUSED_HI:0]   = `PPC_STATUS_LOW_ZERO;

   // Returned levels are the inverted wire, so they match the written bit when the line is healthy
   assign ctl_byte[`PPC_CTL_DIR]                     = ctl_r[`PPC_CTL_DIR];
   assign ctl_byte[`PPC_CTL_RSV_HI:`PPC_CTL_RSV_LO]  = ctl_r[`PPC_CTL_RSV_HI:`PPC_CTL_RSV_LO];
   assign ctl_byte[`PPC_CTL_IRQ_EN]                  = ctl_r[`PPC_CTL_IRQ_EN];
   assign ctl_byte[`PPC_CTL_SELECT_IN]               = ~sel_ret_s2_r;
   assign ctl_byte[`PPC_CTL_INIT]                    = ctl_r[`PPC_CTL_INIT];
   assign ctl_byte[`PPC_CTL_AUTO_FEED]               = ~af_ret_s2_r;
   assign ctl_byte[`PPC_CTL_STROBE]                  = ctl_r[`PPC_CTL_STROBE];

   always_comb begin
      if (sel_data) begin
         rd_mux = pd_s2_r;
      end else if (sel_stat) begin
         rd_mux = status_byte;
      end else if (sel_ctl) begin
         rd_mux = ctl_byte;
      end else begin
         rd_mux = `PPC_RDATA_IDLE;
      end
   end

   assign rdata_nxt = i_io_rd ? rd_mux : `PPC_RDATA_IDLE;

   assign ctl_out_nxt.strobe_drive       = ~ctl_r[`PPC_CTL_STROBE];
   assign ctl_out_nxt.auto_feed_drive    = ~ctl_r[`PPC_CTL_AUTO_FEED];
   assign ctl_out_nxt.printer_init_drive = ctl_r[`PPC_CTL_INIT];
   assign ctl_out_nxt.select_in_drive    = ~ctl_r[`PPC_CTL_SELECT_IN];
   assign sys_irq_nxt = i_port_irq & ctl_r[`PPC_CTL_IRQ_EN];

   // Every output comes straight from a flop
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_io_rdata <= `PPC_RDATA_IDLE;
      end else begin
         o_io_rdata <= rdata_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_pd <= `PPC_DATA_RESET;
      end else begin
         o_pd <= data_r;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_pd_oe <= `PPC_OE_RESET;
      end else begin
         o_pd_oe <= pd_oe_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_ctl <= `PPC_CTL_OUT_RESET;
      end else begin
         o_ctl <= ctl_out_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sys_irq <= `PPC_IRQ_RESET;
      end else begin
         o_sys_irq <= sys_irq_nxt;
      end
   end

endmodule : ppc_printer_port
`default_nettype wire

// [ppc_printer_port_props.sv]
// Port-level assertion checker for the printer port controller
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"
module ppc_printer_port_props (
   // Ports packed per group to keep the checker short
   input wire logic i_clk_sys, i_rst, i_io_wr, i_io_rd, o_pd_oe, i_port_irq, i_bidirection_disable, o_sys_irq,
   input wire logic [`PPC_ADDR_W-1:0] i_io_addr,
   input wire logic [7:0] i_io_wdata, o_io_rdata, o_pd,
   input wire ppc_pkg::ppc_status_in_t i_status,
   input wire ppc_pkg::ppc_ctl_out_t o_ctl
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire       wc = i_io_wr && i_io_addr == `PPC_OFS_CONTROL;
   wire       rc = i_io_rd && i_io_addr == `PPC_OFS_CONTROL;
   wire [3:0] wl = {~i_io_wdata[0], ~i_io_wdata[1], i_io_wdata[2], ~i_io_wdata[3]};
   wire [7:0] sx = {~i_status[4], i_status[3:0], 3'h0};
   property p_data_out; i_io_wr && i_io_addr == `PPC_OFS_DATA |-> ##2 o_pd == $past(i_io_wdata, 2); endproperty
   a_data_out: assert property (p_data_out) else $error("data pins wrong");
   property p_ctl_out; wc |-> ##2 o_ctl == $past(wl, 2); endproperty
   a_ctl_out: assert property (p_ctl_out) else $error("control pins wrong");
   // Inputs pass two synchroniser flops, so only a settled status word is judged
   property p_status; $stable(i_status) [*3] ##0 i_io_rd && i_io_addr == `PPC_OFS_STATUS |=> o_io_rdata == $past(sx); endproperty
   a_status: assert property (p_status) else $error("status word wrong");
   property p_irq; o_sys_irq |-> $past(i_port_irq); endproperty
   a_irq: assert property (p_irq) else $error("irq without request");
   property p_dir_lock; !i_bidirection_disable [*4] |=> o_pd_oe; endproperty
   a_dir_lock: assert property (p_dir_lock) else $error("drivers off while locked");
   property p_dir_in; i_bidirection_disable [*4] ##0 wc && i_io_wdata[7] ##1 !wc |=> !o_pd_oe; endproperty
   a_dir_in: assert property (p_dir_in) else $error("drivers not released");
   property p_ctl_read; wc ##1 rc && !wc |=> (o_io_rdata & 8'h95) == ($past(i_io_wdata, 2) & 8'h95); endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
   property p_ctl_res; rc |=> o_io_rdata[6:5] == 2'h0; endproperty
   a_ctl_res: assert property (p_ctl_res) else $error("reserved bits set");
endmodule : ppc_printer_port_props
`default_nettype wire

// [ppc_printer_model.sv]
// Behavioural printer on the far side of the connector
`timescale 1ns/100ps
`default_nettype none
module ppc_printer_model #(parameter int ACK_CYC = 625) (
   input  wire logic                    i_clk_sys, i_pd_oe,
   input  wire logic [7:0]              i_pd_dev, i_ext,
   input  wire logic [3:0]              i_lines,
   input  wire ppc_pkg::ppc_ctl_out_t   i_ctl,
   output logic [7:0]                   o_pd_wire,
   output ppc_pkg::ppc_status_in_t      o_status,
   output logic                         o_af_ret, o_sel_ret
);
   int   cnt = 0;
   logic stb_q = 1'b1;
   // Acknowledge pulse of 5 us follows each strobe
   // An unknown strobe before reset settles must not start a pulse or poison the count
   always_ff @(posedge i_clk_sys) begin
      stb_q <= i_ctl.strobe_drive;
      if (stb_q === 1'b1 && i_ctl.strobe_drive === 1'b0) begin
         cnt <= ACK_CYC;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   // External equipment drives the wire whenever the port lets go
   assign o_pd_wire = i_pd_oe ? i_pd_dev : i_ext;
   assign o_status  = {i_lines[3], cnt == 0, i_lines[2:0]};
   assign o_af_ret  = i_ctl.auto_feed_drive;
   assign o_sel_ret = i_ctl.select_in_drive;
endmodule : ppc_printer_model
`default_nettype wire

// [ppc_printer_port_tb.sv]
// Self-checking testbench for the printer port controller
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"
module ppc_printer_port_tb;
   logic i_clk_sys = 0, i_rst = 1, i_io_wr = 0, i_io_rd = 0, i_port_irq = 0, i_bidirection_disable = 1;
   logic o_pd_oe, o_sys_irq, i_auto_feed_ret, i_select_in_ret;
   logic [9:0] i_io_addr = '0;
   logic [7:0] i_io_wdata = '0, ext = '0, o_io_rdata, i_pd, o_pd;
   logic [3:0] lines = '0;
   logic [7:0] dv [3] = '{8'hA5, 8'h5A, 8'hFF};
   logic [7:0] cv [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h6F};
   ppc_pkg::ppc_status_in_t i_status;
   ppc_pkg::ppc_ctl_out_t   o_ctl;
   int miscompares = 0, compares = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   ppc_printer_port dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
      .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_pd(i_pd), .o_pd(o_pd),
      .o_pd_oe(o_pd_oe), .i_status(i_status), .i_auto_feed_ret(i_auto_feed_ret),
      .i_select_in_ret(i_select_in_ret), .o_ctl(o_ctl), .i_port_irq(i_port_irq),
      .i_bidirection_disable(i_bidirection_disable), .o_sys_irq(o_sys_irq));
   ppc_printer_model prn (.i_clk_sys, .i_pd_oe(o_pd_oe), .i_pd_dev(o_pd), .i_ext(ext), .i_lines(lines),
      .i_ctl(o_ctl), .o_pd_wire(i_pd), .o_status(i_status), .o_af_ret(i_auto_feed_ret), .o_sel_ret(i_select_in_ret));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic idle(int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : idle
   task automatic wr(logic [9:0] a, logic [7:0] d);
      {i_io_addr, i_io_wdata, i_io_wr} = {a, d, 1'b1};
      idle(1);
      i_io_wr = 0;
   endtask : wr
   task automatic rd(logic [9:0] a, logic [7:0] e, string n);
      {i_io_addr, i_io_rd} = {a, 1'b1};
      idle(1);
      i_io_rd = 0;
      chk(n, o_io_rdata, e);
   endtask : rd
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      idle(10);
      i_rst = 0;
      idle(2);
      rd(`PPC_OFS_CONTROL, 8'h00, "ctl reset");
      foreach (dv[k]) begin
         wr(`PPC_OFS_DATA, dv[k]);
         idle(4);
         chk("pd", o_pd, dv[k]);
         rd(`PPC_OFS_DATA, dv[k], "data");
      end
      foreach (cv[k]) begin
         wr(`PPC_OFS_CONTROL, cv[k]);
         idle(5);
         // Strobe, auto-feed and select-in are inverted on the wire, init is not
         chk("ctl pins", {4'h0, o_ctl ^ 4'hD}, {4'h0, cv[k][0], cv[k][1], cv[k][2], cv[k][3]});
         chk("auto feed", {7'h0, o_ctl.auto_feed_drive}, {7'h0, ~cv[k][1]});
         chk("init", {7'h0, o_ctl.printer_init_drive}, {7'h0, cv[k][2]});
         chk("select in", {7'h0, o_ctl.select_in_drive}, {7'h0, ~cv[k][3]});
         rd(`PPC_OFS_CONTROL, cv[k] & 8'h9F, "ctl");
      end
      ext = 8'h3C;
      wr(`PPC_OFS_CONTROL, 8'h80);
      idle(4);
      chk("oe in", {7'h0, o_pd_oe}, 8'h00);
      rd(`PPC_OFS_DATA, 8'h3C, "data in");
      i_bidirection_disable = 0;
      // Strap sync, output flop and then the data line sync all have to pass
      idle(6);
      chk("oe forced", {7'h0, o_pd_oe}, 8'h01);
      rd(`PPC_OFS_DATA, 8'hFF, "data forced");
      i_bidirection_disable = 1;
      i_port_irq = 1;
      wr(`PPC_OFS_CONTROL, 8'h00);
      idle(3);
      chk("irq blocked", {7'h0, o_sys_irq}, 8'h00);
      wr(`PPC_OFS_CONTROL, 8'h10);
      rd(`PPC_OFS_CONTROL, 8'h10, "ctl back");
      idle(2);
      chk("irq passed", {7'h0, o_sys_irq}, 8'h01);
      i_port_irq = 0;
      // The strobe of the control sweep is still being acknowledged; let that pulse end
      idle(700);
      for (int m = 0; m < 16; m++) begin
         lines = m[3:0];
         idle(4);
         rd(`PPC_OFS_STATUS, {~lines[3], 1'b1, lines[2:0], 3'h0}, "status");
      end
      wr(`PPC_OFS_CONTROL, 8'h01);
      idle(4);
      wr(`PPC_OFS_CONTROL, 8'h00);
      idle(10);
      rd(`PPC_OFS_STATUS, 8'h38, "ack low");
      idle(700);
      rd(`PPC_OFS_STATUS, 8'h78, "ack high");
      wr(10'h037B, 8'hFF);
      rd(10'h037B, 8'h00, "unmapped");
      idle(1);
      rd(`PPC_OFS_CONTROL, 8'h00, "ctl kept");
      complete_run();
   end
   // Whole run needs about 1600 cycles, so 40 us means a hang
   initial begin
      #40000;
      miscompares++;
      complete_run();
   end
endmodule : ppc_printer_port_tb
bind ppc_printer_port ppc_printer_port_props chk_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_io_wr(i_io_wr),
   .i_io_rd(i_io_rd), .o_pd_oe(o_pd_oe), .i_port_irq(i_port_irq), .i_bidirection_disable(i_bidirection_disable),
   .o_sys_irq(o_sys_irq), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
   .o_pd(o_pd), .i_status(i_status), .o_ctl(o_ctl));
`default_nettype wire
